// File: pkg/audio_engine_consts.vh
// Register map and constants for the audio effect and playback engine.
// Included by the core file; definitions only.
`ifndef AUDIO_ENGINE_CONSTS_VH
`define AUDIO_ENGINE_CONSTS_VH

// Register byte offsets
`define OFS_EFFECT_SEL      12'h000
`define OFS_EFFECT_TRIG     12'h004
`define OFS_EFFECT_VOL      12'h008
`define OFS_PB_START        12'h00C
`define OFS_PB_LENGTH       12'h010
`define OFS_PB_RATE         12'h014
`define OFS_PB_FORMAT       12'h018
`define OFS_PB_LOOP         12'h01C
`define OFS_PB_TRIG         12'h020
`define OFS_PB_VOL          12'h024
`define OFS_PB_POSITION     12'h028

// Reset values
`define RST_EFFECT_VOL      8'hFF
`define RST_PB_VOL          8'hFF
`define RST_PB_RATE         16'h1F40

// Playback formats
`define FMT_PCM8            2'h0
`define FMT_MULAW8          2'h1
`define FMT_ADPCM4          2'h2

// Effect codes
`define EFX_SILENCE         8'h00
`define EFX_PITCH_MIN       8'h40
`define EFX_LOOP_MIN        8'h80

// Clock rate and effect tone timing
`define CLK_HZ              32'd50000000
`define EFX_NOTE_MS         32'd200
`define EFX_NOTE_CYC        (`CLK_HZ / 32'd1000 * `EFX_NOTE_MS)

`endif

// File: core/audio_engine.v
// Audio effect synthesizer and sample playback engine with an APB slave.
// Assumes a single pclk domain; sample RAM is on-chip, read with one cycle latency.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "audio_engine_consts.vh"

// How it works
// - One mono PWM pin carries either effect or playback audio.
// - Effect trigger reads 1 while the effect plays, else 0.
// - Looping effects run until a new code plus trigger replaces them.
// - Code 0 with trigger stops any sounding effect.
// - Effect amplitude is scaled by the effect volume register.
// - Effect selection is 16 bits; low byte is effect code.
// - Pitched effects take the upper byte as MIDI note, zero is middle C.
// - Unpitched effects ignore the upper byte.
// - Playback fetches from the start address register.
// - Length gives bytes per pass; exactly that many are consumed.
// - Samples are output at the rate register, in hertz.
// - Format selects PCM8, mu-law8 or ADPCM4, decoded accordingly.
// - Loop 0 plays once; loop 1 restarts at start address forever.
// - Any write to playback trigger starts playback when length is nonzero.
// - Playback trigger reads 1 while playing, else 0.
// - Playback output is scaled by playback volume 0 to 255.
// - ADPCM byte holds low nibble first, then high nibble.
// - Read-only position register shows current playback read address.
module audio_engine #(
	parameter ADDR_W = 16,
	parameter CLK_HZ = 50000000,
	parameter NOTE_CYC = 10000000
) (
	// Clock, reset, enable
	input  wire              pclk,
	input  wire              presetn,
	input  wire              clk_en,
	// APB slave
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [11:0]       paddr,
	input  wire [31:0]       pwdata,
	output reg  [31:0]       prdata,
	output wire              pready,
	output wire              pslverr,
	// Sample RAM read port
	output reg  [ADDR_W-1:0] ram_addr,
	output reg               ram_rd,
	input  wire [7:0]        ram_data,
	// Audio pin
	output reg               audio_pwm
);
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	reg [15:0]       effect_sel_q;
	reg [7:0]        effect_vol_q;
	reg [ADDR_W-1:0] pb_start_q;
	reg [ADDR_W-1:0] pb_length_q;
	reg [15:0]       pb_rate_q;
	reg [1:0]        pb_format_q;
	reg              pb_loop_q;
	reg [7:0]        pb_vol_q;
	reg              efx_play_q;
	reg              pb_play_q;
	reg [ADDR_W-1:0] pb_pos_q;
	reg [ADDR_W-1:0] pb_left_q;
	reg [7:0]        cur_code_q;
	reg [7:0]        cur_note_q;

	wire wr = psel && penable && pwrite;
	wire efx_trig_wr = wr && paddr == `OFS_EFFECT_TRIG;
	wire pb_trig_wr  = wr && paddr == `OFS_PB_TRIG;
	// Code 0 counts as silence, so a trigger with it just stops
	wire efx_start = efx_trig_wr && pwdata[0] && effect_sel_q[7:0] != `EFX_SILENCE;

	// Register writes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			effect_sel_q <= 16'h0000;
			effect_vol_q <= `RST_EFFECT_VOL;
			pb_start_q   <= {ADDR_W{1'b0}};
			pb_length_q  <= {ADDR_W{1'b0}};
			pb_rate_q    <= `RST_PB_RATE;
			pb_format_q  <= `FMT_PCM8;
			pb_loop_q    <= 1'b0;
			pb_vol_q     <= `RST_PB_VOL;
		end else if (clk_en && wr) begin
			if (paddr == `OFS_EFFECT_SEL) begin
				effect_sel_q <= pwdata[15:0];
			end else if (paddr == `OFS_EFFECT_VOL) begin
				effect_vol_q <= pwdata[7:0];
			end else if (paddr == `OFS_PB_START) begin
				pb_start_q <= pwdata[ADDR_W-1:0];
			end else if (paddr == `OFS_PB_LENGTH) begin
				pb_length_q <= pwdata[ADDR_W-1:0];
			end else if (paddr == `OFS_PB_RATE) begin
				pb_rate_q <= pwdata[15:0];
			end else if (paddr == `OFS_PB_FORMAT) begin
				pb_format_q <= pwdata[1:0];
			end else if (paddr == `OFS_PB_LOOP) begin
				pb_loop_q <= pwdata[0];
			end else if (paddr == `OFS_PB_VOL) begin
				pb_vol_q <= pwdata[7:0];
			end
		end
	end

	// Read mux
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (clk_en && psel && !penable && !pwrite) begin
			if (paddr == `OFS_EFFECT_SEL) begin
				prdata <= {16'h0000, effect_sel_q};
			end else if (paddr == `OFS_EFFECT_TRIG) begin
				prdata <= {31'h0, efx_play_q};
			end else if (paddr == `OFS_EFFECT_VOL) begin
				prdata <= {24'h0, effect_vol_q};
			end else if (paddr == `OFS_PB_START) begin
				prdata <= {{(32-ADDR_W){1'b0}}, pb_start_q};
			end else if (paddr == `OFS_PB_LENGTH) begin
				prdata <= {{(32-ADDR_W){1'b0}}, pb_length_q};
			end else if (paddr == `OFS_PB_RATE) begin
				prdata <= {16'h0000, pb_rate_q};
			end else if (paddr == `OFS_PB_FORMAT) begin
				prdata <= {30'h0, pb_format_q};
			end else if (paddr == `OFS_PB_LOOP) begin
				prdata <= {31'h0, pb_loop_q};
			end else if (paddr == `OFS_PB_TRIG) begin
				prdata <= {31'h0, pb_play_q};
			end else if (paddr == `OFS_PB_VOL) begin
				prdata <= {24'h0, pb_vol_q};
			end else if (paddr == `OFS_PB_POSITION) begin
				prdata <= {{(32-ADDR_W){1'b0}}, pb_pos_q};
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// Effect synthesizer: square tone, fixed note length, loops for high codes
	reg [23:0] efx_time_q;
	reg [23:0] efx_phase_q;
	wire       pitched = cur_code_q >= `EFX_PITCH_MIN && cur_code_q < `EFX_LOOP_MIN;
	// Half period in cycles: base from code, or MIDI note offset from middle C
	wire [7:0] note_idx = pitched ? (8'd60 + cur_note_q) : cur_code_q;
	wire [23:0] half_per = 24'd400000 >> note_idx[7:4];
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			efx_play_q  <= 1'b0;
			cur_code_q  <= 8'h00;
			cur_note_q  <= 8'h00;
			efx_time_q  <= 24'h00_0000;
			efx_phase_q <= 24'h00_0000;
		end else if (clk_en) begin
			if (efx_trig_wr && pwdata[0]) begin
				// New trigger abandons whatever plays
				efx_play_q  <= efx_start;
				cur_code_q  <= effect_sel_q[7:0];
				cur_note_q  <= effect_sel_q[15:8];
				efx_time_q  <= 24'h00_0000;
				efx_phase_q <= 24'h00_0000;
			end else if (efx_play_q) begin
				efx_phase_q <= (efx_phase_q >= half_per) ? 24'h00_0000 : efx_phase_q + 24'd1;
				if (efx_time_q == NOTE_CYC[23:0] - 24'd1) begin
					efx_time_q <= 24'h00_0000;
					if (cur_code_q < `EFX_LOOP_MIN)
						efx_play_q <= 1'b0;
				end else begin
					efx_time_q <= efx_time_q + 24'd1;
				end
			end
		end
	end
	reg efx_sq_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			efx_sq_q <= 1'b0;
		end else if (clk_en && efx_play_q && efx_phase_q >= half_per) begin
			efx_sq_q <= ~efx_sq_q;
		end
	end
	wire [7:0] efx_level = efx_sq_q ? effect_vol_q : 8'h00;

	// Sample playback
	localparam PB_IDLE = 2'd0;
	localparam PB_FETCH = 2'd1;
	localparam PB_WAIT = 2'd2;
	reg [1:0]  pb_st_q;
	reg [31:0] rate_acc_q;
	reg        hi_nib_q;
	reg        rd_wait_q;
	reg [7:0]  byte_q;
	reg signed [15:0] sample_q;
	reg signed [15:0] adpcm_pred_q;
	reg [6:0]  adpcm_idx_q;
	wire tick = rate_acc_q + {16'h0, pb_rate_q} >= CLK_HZ;

	// Mu-law expand to 16 bits
	function signed [15:0] mulaw;
		input [7:0] b;
		reg [7:0] n;
		reg [15:0] m;
		begin
			n = ~b;
			m = ((({12'h000, n[3:0]} << 3) + 16'd132) << n[6:4]) - 16'd132;
			mulaw = n[7] ? -$signed(m) : $signed(m);
		end
	endfunction

	// IMA step table, approximated as 7*1.1^idx
	function [15:0] ima_step;
		input [6:0] i;
		integer k;
		reg [31:0] s;
		begin
			s = 32'd7;
			for (k = 0; k < 89; k = k + 1)
				if (k < i)
					s = s + (s / 32'd10) + 32'd1;
			ima_step = (s > 32'd32767) ? 16'h7FFF : s[15:0];
		end
	endfunction

	wire [3:0] nib = hi_nib_q ? byte_q[7:4] : byte_q[3:0];
	wire [15:0] step = ima_step(adpcm_idx_q);
	wire [16:0] diff = {1'b0, step >> 3} + (nib[2] ? {1'b0, step} : 17'h0) +
		(nib[1] ? {2'b0, step[15:1]} : 17'h0) + (nib[0] ? {3'b0, step[15:2]} : 17'h0);
	wire signed [17:0] pred_n = nib[3] ? $signed({{2{adpcm_pred_q[15]}}, adpcm_pred_q}) - $signed({1'b0, diff})
		: $signed({{2{adpcm_pred_q[15]}}, adpcm_pred_q}) + $signed({1'b0, diff});
	wire signed [15:0] pred_c = (pred_n > 18'sd32767) ? 16'sh7FFF :
		(pred_n < -18'sd32768) ? 16'sh8000 : pred_n[15:0];
	wire signed [7:0] idx_adj = nib[2] ? (8'sd2 + $signed({6'h0, nib[1:0]}) * 8'sd2) : -8'sd1;
	wire signed [8:0] idx_n = $signed({2'b0, adpcm_idx_q}) + idx_adj;
	wire [6:0] idx_c = idx_n < 0 ? 7'd0 : (idx_n > 9'sd88 ? 7'd88 : idx_n[6:0]);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pb_st_q      <= PB_IDLE;
			pb_play_q    <= 1'b0;
			pb_pos_q     <= {ADDR_W{1'b0}};
			pb_left_q    <= {ADDR_W{1'b0}};
			rate_acc_q   <= 32'h0000_0000;
			hi_nib_q     <= 1'b0;
			byte_q       <= 8'h00;
			sample_q     <= 16'sh0000;
			adpcm_pred_q <= 16'sh0000;
			adpcm_idx_q  <= 7'd0;
			ram_addr     <= {ADDR_W{1'b0}};
			ram_rd       <= 1'b0;
			rd_wait_q    <= 1'b0;
		end else if (clk_en) begin
			ram_rd <= 1'b0;
			// RAM data shows one cycle after the strobe, not with it
			rd_wait_q <= ram_rd;
			if (pb_trig_wr) begin
				// Any written value starts playback unless length is zero
				pb_play_q    <= pb_length_q != 0;
				pb_st_q      <= (pb_length_q != 0) ? PB_FETCH : PB_IDLE;
				pb_pos_q     <= pb_start_q;
				pb_left_q    <= pb_length_q;
				rate_acc_q   <= 32'h0000_0000;
				hi_nib_q     <= 1'b0;
				adpcm_pred_q <= 16'sh0000;
				adpcm_idx_q  <= 7'd0;
			end else begin
				if (pb_play_q)
					rate_acc_q <= tick ? rate_acc_q + {16'h0, pb_rate_q} - CLK_HZ
						: rate_acc_q + {16'h0, pb_rate_q};
				case (pb_st_q)
				PB_FETCH: begin
					ram_addr <= pb_pos_q;
					ram_rd   <= 1'b1;
					pb_st_q  <= PB_WAIT;
				end
				PB_WAIT: begin
					if (rd_wait_q)
						byte_q <= ram_data;
					if (!ram_rd && !rd_wait_q && tick) begin
						// Decode one sample per rate tick
						if (pb_format_q == `FMT_ADPCM4) begin
							sample_q     <= pred_c;
							adpcm_pred_q <= pred_c;
							adpcm_idx_q  <= idx_c;
						end else if (pb_format_q == `FMT_MULAW8) begin
							sample_q <= mulaw(byte_q);
						end else begin
							sample_q <= {byte_q, 8'h00};
						end
						hi_nib_q <= (pb_format_q == `FMT_ADPCM4) && !hi_nib_q;
						if (pb_format_q != `FMT_ADPCM4 || hi_nib_q) begin
							// Byte consumed
							if (pb_left_q == 1) begin
								if (pb_loop_q) begin
									pb_pos_q  <= pb_start_q;
									pb_left_q <= pb_length_q;
									pb_st_q   <= PB_FETCH;
								end else begin
									pb_play_q <= 1'b0;
									pb_st_q   <= PB_IDLE;
								end
							end else begin
								pb_pos_q  <= pb_pos_q + 1'b1;
								pb_left_q <= pb_left_q - 1'b1;
								pb_st_q   <= PB_FETCH;
							end
						end
					end
				end
				default: pb_st_q <= PB_IDLE;
				endcase
			end
		end
	end

	// Volume scale, offset binary for PWM
	wire [15:0] pb_mag = {8'h00, sample_q[15:8] ^ 8'h80};
	wire [15:0] pb_scaled = pb_play_q ? pb_mag * {8'h00, pb_vol_q} : 16'h0000;
	wire [7:0]  pb_level = pb_scaled[15:8];
	// Playback takes the pin while running, effects otherwise
	wire [7:0]  level = pb_play_q ? pb_level : efx_level;

	reg [7:0] pwm_cnt_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_cnt_q <= 8'h00;
			audio_pwm <= 1'b0;
		end else if (clk_en) begin
			pwm_cnt_q <= pwm_cnt_q + 8'd1;
			audio_pwm <= pwm_cnt_q < level;
		end
	end

endmodule
`default_nettype wire

// File: bench/audio_engine_properties.sv
// Checker for the audio engine APB and sample fetch ports.
// Assumes playback registers are rewritten only while playback is idle.
`timescale 1ns/1ns
`default_nettype none
`include "audio_engine_consts.vh"
module audio_engine_properties #(
	parameter ADDR_W = 16,
	parameter CLK_HZ = 50000000
) (
	// Clock and APB
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              clk_en,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// RAM and pin
	input wire logic [ADDR_W-1:0] ram_addr,
	input wire logic              ram_rd,
	input wire logic [7:0]        ram_data,
	input wire logic              audio_pwm
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic              wr;
	logic [ADDR_W-1:0] start_q, last_q;
	logic [31:0]       len_q, cnt_q, gap_q;
	logic [15:0]       rate_q;
	logic [1:0]        fmt_q, nth_q;
	logic              loop_q;
	assign wr = psel && penable && pwrite && clk_en;
	sequence pb_go;
		wr && paddr == `OFS_PB_TRIG && len_q != 32'h0;
	endsequence
	sequence fetch_soon;
		##[1:1000] ram_rd;
	endsequence
	// Shadow of playback setup, so fetch order can be predicted
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{start_q, last_q, len_q, cnt_q, gap_q, fmt_q, nth_q, loop_q} <= '0;
			rate_q <= `RST_PB_RATE;
		end else if (clk_en) begin
			gap_q <= ram_rd ? 32'h1 : gap_q + 32'h1;
			if (wr && paddr == `OFS_PB_START) start_q <= pwdata[ADDR_W-1:0];
			if (wr && paddr == `OFS_PB_LENGTH) len_q <= pwdata;
			if (wr && paddr == `OFS_PB_RATE) rate_q <= pwdata[15:0];
			if (wr && paddr == `OFS_PB_FORMAT) fmt_q <= pwdata[1:0];
			if (wr && paddr == `OFS_PB_LOOP) loop_q <= pwdata[0];
			if (wr && paddr == `OFS_PB_TRIG) begin
				nth_q <= 2'h0;
			end else if (ram_rd) begin
				nth_q <= (nth_q == 2'h3) ? nth_q : nth_q + 2'h1;
				last_q <= ram_addr;
				cnt_q <= (nth_q == 2'h0 || cnt_q == len_q) ? 32'h1 : cnt_q + 32'h1;
			end
		end
	end
	pb_fetch_a: assert property (pb_go |-> fetch_soon)
		else $error("no fetch after playback trigger");
	first_addr_a: assert property (ram_rd && nth_q == 2'h0 |-> ram_addr == start_q)
		else $error("first fetch not at start address");
	addr_step_a: assert property (ram_rd && nth_q != 2'h0 |->
		ram_addr == (cnt_q == len_q ? start_q : last_q + 1'b1)) else $error("bad fetch address");
	once_only_a: assert property (ram_rd && nth_q != 2'h0 && !loop_q |-> cnt_q < len_q)
		else $error("fetch beyond length");
	rate_gap_a: assert property (ram_rd && nth_q >= 2'h2 |->
		gap_q == CLK_HZ / rate_q * (fmt_q == `FMT_ADPCM4 ? 2 : 1)) else $error("bad fetch spacing");
	rd_pulse_a: assert property (ram_rd |=> !ram_rd)
		else $error("fetch pulse too long");
	rd_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data moved outside read setup");
	apb_resp_a: assert property (pready && !pslverr)
		else $error("bad APB response");
endmodule
bind audio_engine audio_engine_properties #(.ADDR_W(ADDR_W), .CLK_HZ(CLK_HZ)) u_props (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .ram_addr(ram_addr), .ram_rd(ram_rd), .ram_data(ram_data),
	.audio_pwm(audio_pwm));
`default_nettype wire

// File: bench/sample_ram_model.sv
// Sample RAM model on the engine's read port.
// Assumes one-cycle read latency; data is invalid outside that cycle.
`timescale 1ns/1ns
`default_nettype none
module sample_ram_model #(
	parameter ADDR_W = 16
) (
	// Read port
	input wire logic              pclk,
	input wire logic              ram_rd,
	input wire logic [ADDR_W-1:0] ram_addr,
	output var logic [7:0]        ram_data
);
	initial ram_data = 8'h00;
	// Fixed content stands in for host-loaded samples
	always @(posedge pclk) begin
		if (ram_rd)
			ram_data <= ram_addr[7:0] ^ 8'hA5;
		else
			ram_data <= ~ram_data;  // Never leave a stale byte looking valid
	end
endmodule
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the audio engine.
// Assumes a zero-wait APB slave and a 50 MHz pclk.
`timescale 1ns/1ns
`default_nettype none
`include "audio_engine_consts.vh"
module tb;
	logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, ram_rd, audio_pwm;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] ram_addr;
	logic [7:0]  ram_data;
	int          failures, checks_done, rd_cnt = 0;
	audio_engine #(.NOTE_CYC(1000)) DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ram_addr(ram_addr),
		.ram_rd(ram_rd), .ram_data(ram_data), .audio_pwm(audio_pwm));
	sample_ram_model ram (.pclk(pclk), .ram_rd(ram_rd), .ram_addr(ram_addr), .ram_data(ram_data));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) if (ram_rd) rd_cnt <= rd_cnt + 1;
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			failures++;
			$display("[ERR] pready expected 1 seen %b", pready);
			give_verdict;
		end
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rdat);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0, rdat);
		chk(nm, e, rdat);
	endtask
	// Polls a busy flag; a bound keeps a stuck flag from hanging the run
	task automatic wait_done(input logic [11:0] a, input int lim);
		int n;
		n = 0;
		rdat = 32'h1;
		while (rdat !== 32'h0 && n < lim) begin
			apb(1'b0, a, 32'h0, rdat);
			n++;
		end
		chk("busy flag", 32'h0, rdat);
		if (rdat !== 32'h0) give_verdict;
	endtask
	// Counts high samples of the audio pin over a window
	task automatic count_pwm(input int len, output int hi);
		hi = 0;
		repeat (len) begin
			@(posedge pclk);
			if (audio_pwm === 1'b1) hi++;
		end
	endtask
	task automatic do_reset;
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	task automatic t_regs;
		rd(`OFS_EFFECT_VOL, 32'h0000_00FF, "effect_volume");
		rd(`OFS_PB_VOL, 32'h0000_00FF, "playback_volume");
		rd(`OFS_PB_RATE, 32'h0000_1F40, "sample_rate_hz");
		rd(12'h0FC, 32'h0, "unmapped");
		wr(`OFS_PB_POSITION, 32'h0000_0055);
		rd(`OFS_PB_POSITION, 32'h0, "playback_position");
		wr(`OFS_EFFECT_SEL, 32'hABCD_1234);
		rd(`OFS_EFFECT_SEL, 32'h0000_1234, "effect_selection");
		clk_en <= 1'b0;
		wr(`OFS_PB_VOL, 32'h0000_0012);
		clk_en <= 1'b1;
		rd(`OFS_PB_VOL, 32'h0000_00FF, "frozen write");
		wr(`OFS_PB_VOL, 32'h0000_0080);
		rd(`OFS_PB_VOL, 32'h0000_0080, "playback_volume");
	endtask
	task automatic t_effect;
		int hi;
		wr(`OFS_EFFECT_SEL, 32'h0000_0080);
		wr(`OFS_EFFECT_TRIG, 32'h0000_0001);
		rd(`OFS_EFFECT_TRIG, 32'h1, "effect busy");
		count_pwm(3000, hi);
		chk("effect tone", 32'h1, {31'h0, hi > 0});
		rd(`OFS_EFFECT_TRIG, 32'h1, "looping effect");
		wr(`OFS_EFFECT_VOL, 32'h0000_0000);
		count_pwm(600, hi);
		chk("muted effect", 32'h0, hi);
		wr(`OFS_EFFECT_VOL, 32'h0000_00FF);
		wr(`OFS_EFFECT_SEL, 32'h0000_3C41);
		wr(`OFS_EFFECT_TRIG, 32'h0000_0001);
		rd(`OFS_EFFECT_TRIG, 32'h1, "pitched effect");
		wait_done(`OFS_EFFECT_TRIG, 5000);
		wr(`OFS_EFFECT_SEL, 32'h0000_0080);
		wr(`OFS_EFFECT_TRIG, 32'h0000_0001);
		wr(`OFS_EFFECT_SEL, 32'h0000_0000);
		wr(`OFS_EFFECT_TRIG, 32'h0000_0001);
		rd(`OFS_EFFECT_TRIG, 32'h0, "silence");
	endtask
	task automatic t_play(input logic [1:0] fmt);
		int c0;
		wr(`OFS_PB_START, 32'h0000_0010);
		wr(`OFS_PB_LENGTH, 32'h0000_0005);
		wr(`OFS_PB_RATE, 32'h0000_F424);
		wr(`OFS_PB_FORMAT, {30'h0, fmt});
		wr(`OFS_PB_LOOP, 32'h0);
		c0 = rd_cnt;
		wr(`OFS_PB_TRIG, 32'h0);
		rd(`OFS_PB_TRIG, 32'h1, "playback busy");
		wait_done(`OFS_PB_TRIG, 4000);
		chk("bytes fetched", 32'h0000_0005, rd_cnt - c0);
	endtask
	task automatic t_loop;
		int c0;
		int hi;
		c0 = rd_cnt;
		wr(`OFS_PB_LENGTH, 32'h0000_0003);
		wr(`OFS_PB_LOOP, 32'h1);
		wr(`OFS_PB_VOL, 32'h0000_0000);
		wr(`OFS_EFFECT_SEL, 32'h0000_0080);
		wr(`OFS_EFFECT_TRIG, 32'h0000_0001);
		wr(`OFS_PB_TRIG, 32'h1);
		count_pwm(2000, hi);
		chk("playback over effect", 32'h0, hi);
		repeat (6000) @(posedge pclk);
		rd(`OFS_PB_TRIG, 32'h1, "looping playback");
		chk("loop refetch", 32'h1, {31'h0, rd_cnt - c0 > 3});
		apb(1'b0, `OFS_PB_POSITION, 32'h0, rdat);
		chk("position window", 32'h1, {31'h0, rdat >= 32'h10 && rdat <= 32'h12});
		do_reset;
		rd(`OFS_PB_TRIG, 32'h0, "stopped by reset");
	endtask
	initial begin
		presetn = 1'b0;
		clk_en = 1'b1;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		failures = 0;
		checks_done = 0;
		@(posedge pclk);
		do_reset;
		t_regs;
		t_effect;
		for (int f = 0; f < 3; f++) t_play(f[1:0]);
		t_loop;
		give_verdict;
	end
endmodule
`default_nettype wire
